//--- hw/mmd_decoder.sv
// Purpose: Resolve bus addresses to flash sectors, external selects or system frames.
// Assumes: One request at a time, taken while reqReady is high.
// Notes:   Program and erase are sequenced; answers carry the decoded target.
`timescale 1ns/10ps
`default_nettype none

module mmd_decoder
  import mmd_pkg::*;
#(
  parameter bit          REDUCED_FLASH = 1'b0,
  parameter int unsigned CLK_HZ        = mmd_pkg::SYS_CLK_HZ,
  parameter int unsigned PROG_CYC      = mmd_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_CYC     = mmd_pkg::ERASE_CYCLES
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // Request
  input  wire logic              reqValid,
  input  wire mmd_pkg::mmd_req_t reqData,
  output var  logic              reqReady,
  // Answer
  output var  logic              respValid,
  output var  mmd_pkg::mmd_resp_t respData,
  // Configuration
  input  wire logic              eccEnable,
  input  wire logic              overlayEnable,
  input  wire logic              frcWrite,
  input  wire logic [2:0]        frcData,
  input  wire logic              extWidthWrite,
  input  wire logic              extWidth8,
  input  wire logic              gpioRequest,
  // Status
  output var  logic [2:0]        flashReadControl,
  output var  logic [1:0]        extWidth,
  output var  logic              flashBusy,
  output var  logic              clockLimitViolation,
  output var  logic              extPinGpioMode,
  output var  logic [31:0]       eraseFirst,
  output var  logic [31:0]       eraseLast
);

  import mmd_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial
  begin
    if (CLK_HZ > PIPE_MAX_HZ)
      $error("mmd_decoder: clock above pipeline flash limit");
    if (PROG_CYC < 1 || PROG_CYC > 255 || ERASE_CYC < 1 || ERASE_CYC > 255)
      $error("mmd_decoder: sequencer counts out of range");
  end

  localparam int unsigned CS_LSB = $clog2(EXT_CS_SPAN);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BEAT = 3'b010,
    ST_SEQ  = 3'b100
  } mmd_state_t;

  mmd_state_t  state_reg;
  mmd_state_t  state_next;
  logic [7:0]  count_reg;
  logic [7:0]  count_next;
  logic        respValid_reg;
  logic        respValid_next;
  mmd_resp_t   resp_reg;
  mmd_resp_t   resp_next;
  logic [2:0]  frc_reg;
  logic [1:0]  extWidth_reg;
  logic        busy_reg;
  logic        clkViol_reg;
  logic        gpio_reg;
  logic        ready_reg;
  logic [31:0] eraseFirst_reg;
  logic [31:0] eraseFirst_next;
  logic [31:0] eraseLast_reg;
  logic [31:0] eraseLast_next;

  // ----------------------------------------------------------------
  // Flash decode
  // ----------------------------------------------------------------
  wire logic [31:0] addr      = reqData.addr;
  wire logic [18:0] bOff      = addr[18:0];
  wire logic [1:0]  bank      = addr[20:19];
  wire logic        inFlash   = addr <= FLASH_LAST;
  wire logic        bankGone  = REDUCED_FLASH && bank[1];
  wire logic        b0In32    = bOff < B0_8K_START;
  wire logic        b0In8     = !b0In32 && (bOff < B0_16K_START);
  wire logic        b0In16    = !b0In32 && !b0In8 && (bOff < B0_64K_START);
  wire logic        b0In64    = (bOff >= B0_64K_START) && (bOff < B0_128K_START);
  wire logic [3:0]  b0Sector  = b0In32 ? {2'h0, bOff[16:15]} :
                                b0In8  ? (4'h3 + {3'h0, bOff[13]}) :
                                b0In16 ? 4'h5 :
                                b0In64 ? (4'h6 + {3'h0, bOff[16]}) :
                                         (4'h8 + {3'h0, bOff[17]});
  wire logic [18:0] b0Mask    = b0In32 ? MASK_32K :
                                b0In8  ? MASK_8K :
                                b0In16 ? MASK_16K :
                                b0In64 ? MASK_64K : MASK_128K;
  wire logic [3:0]  sector    = (bank == 2'h0) ? b0Sector :
                                               {2'h0, bOff[18:17]};
  wire logic [18:0] secMask   = (bank == 2'h0) ? b0Mask : MASK_128K;
  wire logic [31:0] secFirst  = addr & ~{13'h0, secMask};
  wire logic [31:0] secLast   = addr | {13'h0, secMask};
  wire logic        flashOk   = inFlash && !bankGone;

  // ----------------------------------------------------------------
  // Overlay and external decode
  // ----------------------------------------------------------------
  wire logic [31:0] ovlOff    = addr - OVL_BASE;
  wire logic        ovlHit    = overlayEnable && (addr >= OVL_BASE) &&
                                (ovlOff < OVL_SIZE);
  wire logic [31:0] ovlAddr   = EXT_BASE + ovlOff;
  wire logic [31:0] extOff    = addr - EXT_BASE;
  wire logic        extHit    = (addr >= EXT_BASE) &&
                                (extOff[31:CS_LSB] < 4);
  wire logic [1:0]  extSel    = extOff[CS_LSB+1:CS_LSB];
  wire logic [31:0] inSelOff  = extOff & (EXT_CS_SPAN - 32'h0000_0001);
  wire logic [31:0] extLimit  = (extWidth_reg == EXT_WIDTH_8) ? EXT_LIM_8 :
                                                               EXT_LIM_16;
  wire logic        extOk     = extHit && (inSelOff < extLimit);

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  logic [NFRAME-1:0] frameHit;

  genvar gi;
  generate
    for (gi = 0; gi < NFRAME; gi++)
    begin : g_frame
      mmd_range_match #(
        .BASE (FRAME_BASE[gi]),
        .LAST (FRAME_LAST[gi])
      ) u_match (
        .addr (addr),
        .hit  (frameHit[gi])
      );
    end
  endgenerate

  logic [4:0] frameIdx;

  always_comb
  begin
    frameIdx = 5'h0;
    for (int i = NFRAME - 1; i >= 0; i--)
    begin
      if (frameHit[i])
        frameIdx = 5'(i);
    end
  end

  // ----------------------------------------------------------------
  // Request checks
  // ----------------------------------------------------------------
  wire logic       pipeOn    = |frc_reg;
  wire logic       isRead    = reqData.kind == KIND_READ;
  wire logic       isProg    = reqData.kind == KIND_PROG;
  wire logic       isErase   = reqData.kind == KIND_ERASE;
  // The reserved kind would be an EEPROM emulation access; it is refused.
  wire logic       kindBad   = reqData.kind == KIND_RSVD;
  wire logic       sizeOk    = (reqData.size == SIZE_WORD && addr[1:0] == 2'h0) ||
                               (reqData.size == SIZE_HALF && !addr[0]);
  wire mmd_tgt_t   tgt       = ovlHit ? TGT_EXT :
                               flashOk ? TGT_FLASH :
                               extOk ? TGT_EXT :
                               (|frameHit) ? TGT_FRAME : TGT_NONE;
  wire logic       onFlash   = !ovlHit && flashOk;
  wire logic       progBad   = isProg && (!onFlash || !sizeOk);
  wire logic       eraseBad  = isErase && !onFlash;
  wire logic       decErr    = (tgt == TGT_NONE) || kindBad ||
                               progBad || eraseBad;
  wire logic       eccHit    = ovlHit && eccEnable;
  wire logic       startSeq  = !decErr && (isProg || isErase);
  wire logic       twoBeat   = !decErr && isRead && onFlash && pipeOn;
  wire logic [31:0] lineAddr = {addr[31:4], 4'h0};
  wire logic [7:0] seqLen    = isErase ? 8'(ERASE_CYC) : 8'(PROG_CYC);

  // ----------------------------------------------------------------
  // Answer assembly
  // ----------------------------------------------------------------
  mmd_resp_t decResp;

  always_comb
  begin
    decResp           = '0;
    decResp.target    = decErr ? TGT_NONE : tgt;
    decResp.bank      = onFlash ? bank : 2'h0;
    decResp.sector    = onFlash ? sector : 4'h0;
    decResp.extSelect = (ovlHit || !extOk) ? 2'h0 : extSel;
    decResp.frame     = (tgt == TGT_FRAME) ? frameIdx : 5'h0;
    decResp.addr      = ovlHit ? ovlAddr : (twoBeat ? lineAddr : addr);
    decResp.busError  = decErr;
    decResp.eccError  = eccHit && !decErr;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next      = state_reg;
    count_next      = count_reg;
    respValid_next  = 1'b0;
    resp_next       = resp_reg;
    eraseFirst_next = eraseFirst_reg;
    eraseLast_next  = eraseLast_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (reqValid)
        begin
          resp_next = decResp;
          if (startSeq)
          begin
            state_next = ST_SEQ;
            count_next = seqLen - 8'h01;
            if (isErase)
            begin
              eraseFirst_next = secFirst;
              eraseLast_next  = secLast;
            end
          end
          else
          begin
            respValid_next = 1'b1;
            if (twoBeat)
              state_next = ST_BEAT;
          end
        end
      end
      ST_BEAT:
      begin
        respValid_next = 1'b1;
        resp_next.beat = 1'b1;
        resp_next.addr = resp_reg.addr + 32'h0000_0008;
        state_next     = ST_IDLE;
      end
      ST_SEQ:
      begin
        if (count_reg == 8'h00)
        begin
          respValid_next = 1'b1;
          state_next     = ST_IDLE;
        end
        else
          count_next = count_reg - 8'h01;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  wire logic readyNext = (state_next == ST_IDLE);
  wire logic busyNext  = (state_next == ST_SEQ);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  wire logic [2:0] frcNext   = frcWrite ? frcData : frc_reg;
  wire logic [1:0] widthNext = extWidthWrite ?
                               (extWidth8 ? EXT_WIDTH_8 : EXT_WIDTH_16) :
                               extWidth_reg;
  // Only a static flag is possible here: the decoder cannot slow the clock.
  wire logic       violNext  = !(|frcNext) && (CLK_HZ > NONPIPE_MAX_HZ);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state_reg      <= ST_IDLE;
      count_reg      <= 8'h00;
      respValid_reg  <= 1'b0;
      resp_reg       <= '0;
      eraseFirst_reg <= 32'h0000_0000;
      eraseLast_reg  <= 32'h0000_0000;
      ready_reg      <= 1'b0;
      busy_reg       <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      count_reg      <= count_next;
      respValid_reg  <= respValid_next;
      resp_reg       <= resp_next;
      eraseFirst_reg <= eraseFirst_next;
      eraseLast_reg  <= eraseLast_next;
      ready_reg      <= readyNext;
      busy_reg       <= busyNext;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      frc_reg      <= FRC_RESET;
      extWidth_reg <= EXT_WIDTH_16;
      clkViol_reg  <= (CLK_HZ > NONPIPE_MAX_HZ);
      gpio_reg     <= 1'b0;
    end
    else
    begin
      frc_reg      <= frcNext;
      extWidth_reg <= widthNext;
      clkViol_reg  <= violNext;
      // A general purpose request on the external pins is never granted.
      gpio_reg     <= gpioRequest && 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reqReady            = ready_reg;
  assign respValid           = respValid_reg;
  assign respData            = resp_reg;
  assign flashReadControl    = frc_reg;
  assign extWidth            = extWidth_reg;
  assign flashBusy           = busy_reg;
  assign clockLimitViolation = clkViol_reg;
  assign extPinGpioMode      = gpio_reg;
  assign eraseFirst          = eraseFirst_reg;
  assign eraseLast           = eraseLast_reg;

endmodule : mmd_decoder

`default_nettype wire

//--- hw/mmd_pkg.sv
// Purpose: Shared constants, types and address map for the memory map decoder.
// Assumes: 32-bit byte addresses; one system clock.
// Notes:   Frame table order defines the frame index reported on a hit.
//
// Behaviour
// - Overlay window maps onto the lowest 4MB of external select zero.
// - Overlay read while ECC checking is enabled raises an ECC error.
// - 16-bit external memory reaches only the lowest 32MB per select.
// - 8-bit external memory reaches only the lowest 16MB per select.
// - External data width is 16 bits after reset until software changes it.
// - External memory interface pins never act as general purpose io pins.
// - Full flash is four 512K banks, 22 sectors, bank taken from address.
// - Reduced flash has banks 0 and 1 only, 14 sectors; others undecoded.
// - Bank 0: three 32K, two 8K, one 16K, two 64K, two 128K sectors.
// - Banks 1 to 3 are each four 128K sectors up to 0x001F_FFFF.
// - Non-pipeline flash reads allow at most 36MHz; pipeline up to 160MHz.
// - Pipeline read fetches 128 bits and delivers two 64-bit beats.
// - Erase covers a whole sector; program and erase run in a sequencer.
// - A program writes exactly one 32-bit word or one 16-bit half word.
// - After reset the flash read control field is 000, non-pipeline mode.
// - No EEPROM emulation mode exists.
// - Checksum frame 0xFE00_0000..0xFEFF_FFFF; five 4KB debug frames at 0xFFA0_0000.
// - RAM, flash wrapper frames at 0xFFF8_xxxx; system frames 0xFFFF_E000 up.

package mmd_pkg;

  // ----------------------------------------------------------------
  // Clock and flash timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ      = 10_000_000;
  localparam int unsigned PIPE_MAX_HZ     = 160_000_000;
  localparam int unsigned NONPIPE_MAX_HZ  = 36_000_000;
  localparam int unsigned PROG_CYCLES     = 4;
  localparam int unsigned ERASE_CYCLES    = 16;

  // ----------------------------------------------------------------
  // Flash layout
  // ----------------------------------------------------------------
  localparam logic [31:0] FLASH_LAST      = 32'h001F_FFFF;
  localparam logic [18:0] B0_8K_START     = 19'h1_8000;
  localparam logic [18:0] B0_16K_START    = 19'h1_C000;
  localparam logic [18:0] B0_64K_START    = 19'h2_0000;
  localparam logic [18:0] B0_128K_START   = 19'h4_0000;
  localparam logic [18:0] MASK_8K         = 19'h0_1FFF;
  localparam logic [18:0] MASK_16K        = 19'h0_3FFF;
  localparam logic [18:0] MASK_32K        = 19'h0_7FFF;
  localparam logic [18:0] MASK_64K        = 19'h0_FFFF;
  localparam logic [18:0] MASK_128K       = 19'h1_FFFF;
  localparam logic [2:0]  FRC_RESET       = 3'h0;
  localparam logic [1:0]  EXT_WIDTH_8     = 2'h1;
  localparam logic [1:0]  EXT_WIDTH_16    = 2'h2;

  // ----------------------------------------------------------------
  // External memory and overlay window
  // ----------------------------------------------------------------
  localparam logic [31:0] EXT_BASE        = 32'h6000_0000;
  localparam logic [31:0] EXT_CS_SPAN     = 32'h0800_0000;
  localparam logic [31:0] EXT_LIM_16      = 32'h0200_0000;
  localparam logic [31:0] EXT_LIM_8       = 32'h0100_0000;
  localparam logic [31:0] OVL_BASE        = 32'h0000_0000;
  localparam logic [31:0] OVL_SIZE        = 32'h0040_0000;

  // ----------------------------------------------------------------
  // System frames
  // ----------------------------------------------------------------
  localparam int unsigned NFRAME = 26;
  localparam logic [31:0] FRAME_BASE [NFRAME] = '{
    32'hFE00_0000, 32'hFFA0_0000, 32'hFFA0_1000, 32'hFFA0_2000, 32'hFFA0_3000,
    32'hFFA0_4000, 32'hFFF8_0000, 32'hFFF8_2000, 32'hFFF8_3000, 32'hFFF8_7000,
    32'hFFFF_E000, 32'hFFFF_E100, 32'hFFFF_E400, 32'hFFFF_E600, 32'hFFFF_E800,
    32'hFFFF_F000, 32'hFFFF_F500, 32'hFFFF_F600, 32'hFFFF_F700, 32'hFFFF_F800,
    32'hFFFF_F900, 32'hFFFF_FA00, 32'hFFFF_FC00, 32'hFFFF_FD00, 32'hFFFF_FE00,
    32'hFFFF_FF00};
  localparam logic [31:0] FRAME_LAST [NFRAME] = '{
    32'hFEFF_FFFF, 32'hFFA0_0FFF, 32'hFFA0_1FFF, 32'hFFA0_2FFF, 32'hFFA0_3FFF,
    32'hFFA0_4FFF, 32'hFFF8_0FFF, 32'hFFF8_2FFF, 32'hFFF8_3FFF, 32'hFFF8_7FFF,
    32'hFFFF_E0FF, 32'hFFFF_E1FF, 32'hFFFF_E5FF, 32'hFFFF_E6FF, 32'hFFFF_E8FF,
    32'hFFFF_F3FF, 32'hFFFF_F5FF, 32'hFFFF_F6FF, 32'hFFFF_F7FF, 32'hFFFF_F8FF,
    32'hFFFF_F9FF, 32'hFFFF_FAFF, 32'hFFFF_FCFF, 32'hFFFF_FDFF, 32'hFFFF_FEFF,
    32'hFFFF_FFFF};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_READ  = 2'h0,
    KIND_PROG  = 2'h1,
    KIND_ERASE = 2'h2,
    KIND_RSVD  = 2'h3
  } mmd_kind_t;

  typedef enum logic [1:0] {
    SIZE_BYTE  = 2'h0,
    SIZE_HALF  = 2'h1,
    SIZE_WORD  = 2'h2,
    SIZE_DWORD = 2'h3
  } mmd_size_t;

  typedef enum logic [1:0] {
    TGT_NONE  = 2'h0,
    TGT_FLASH = 2'h1,
    TGT_EXT   = 2'h2,
    TGT_FRAME = 2'h3
  } mmd_tgt_t;

  typedef struct packed {
    logic [31:0] addr;
    mmd_kind_t   kind;
    mmd_size_t   size;
  } mmd_req_t;

  typedef struct packed {
    mmd_tgt_t    target;
    logic [1:0]  bank;
    logic [3:0]  sector;
    logic [1:0]  extSelect;
    logic [4:0]  frame;
    logic [31:0] addr;
    logic        beat;
    logic        busError;
    logic        eccError;
  } mmd_resp_t;

endpackage : mmd_pkg

//--- hw/mmd_range_match.sv
// Purpose: Inclusive address range comparator for one frame.
// Assumes: BASE is not above LAST.
// Notes:   One instance per frame of the system map.
`timescale 1ns/10ps
`default_nettype none

module mmd_range_match #(
  parameter logic [31:0] BASE = 32'h0000_0000,
  parameter logic [31:0] LAST = 32'h0000_0FFF
) (
  // Address in
  input  wire logic [31:0] addr,
  // Match out
  output wire logic        hit
);

  initial
  begin
    if (BASE > LAST)
      $error("mmd_range_match: BASE above LAST");
  end

  assign hit = (addr >= BASE) && (addr <= LAST);

endmodule : mmd_range_match

`default_nettype wire

//--- bench/mmd_decoder_monitor.sv
// Purpose: Port-level checks for the memory map decoder.
// Assumes: Bound to mmd_decoder; one clock, synchronous active-low reset.
// Notes:   Busy length is compared against both sequencer counts.
`timescale 1ns/10ps
`default_nettype none
module mmd_decoder_monitor
  import mmd_pkg::*;
#(
  parameter int unsigned PROG_CYC  = 4,
  parameter int unsigned ERASE_CYC = 16
) (
  input wire logic               clk_sys,
  input wire logic               nrst,
  input wire logic               reqValid,
  input wire mmd_pkg::mmd_req_t  reqData,
  input wire logic               reqReady,
  input wire logic               respValid,
  input wire mmd_pkg::mmd_resp_t respData,
  input wire logic               eccEnable,
  input wire logic               overlayEnable,
  input wire logic [2:0]         flashReadControl,
  input wire logic [1:0]         extWidth,
  input wire logic               flashBusy,
  input wire logic               extPinGpioMode
);
  logic [8:0] busyCnt_reg;
  always_ff @(posedge clk_sys)
    busyCnt_reg <= (nrst && flashBusy) ? busyCnt_reg + 9'h1 : 9'h0;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  reset_defaults_a: assert property (!$past(nrst) |-> flashReadControl == 3'h0 && extWidth == 2'h2)
    else $error("reset defaults wrong");
  gpio_never_a: assert property (extPinGpioMode == 1'b0) else $error("pins in gpio mode");
  busy_length_a: assert property ($fell(flashBusy) |-> respValid && (busyCnt_reg == PROG_CYC || busyCnt_reg == ERASE_CYC))
    else $error("sequencer length wrong");
  pipe_beats_a: assert property (respValid && respData.target == TGT_FLASH && !respData.beat && flashReadControl != 3'h0
    && !$past(flashBusy) |=> respValid && respData.beat && respData.addr == $past(respData.addr) + 32'h8)
    else $error("second beat wrong");
  error_target_a: assert property (respValid && respData.busError |-> respData.target == TGT_NONE)
    else $error("error answer has target");
  bank_index_a: assert property (respValid && respData.target == TGT_FLASH |-> respData.bank == respData.addr[20:19])
    else $error("bank index wrong");
  upper_sector_a: assert property (respValid && respData.target == TGT_FLASH && respData.bank != 2'h0
    |-> respData.sector == {2'h0, respData.addr[18:17]}) else $error("sector wrong");
  ext_limit_a: assert property (respValid && respData.target == TGT_EXT
    |-> respData.addr[26:0] < (extWidth == 2'h1 ? 27'h100_0000 : 27'h200_0000)) else $error("ext limit");
  ecc_cause_a: assert property (respValid && respData.eccError
    |-> respData.target == TGT_EXT && $past(eccEnable)) else $error("ecc error without cause");
  overlay_map_a: assert property (reqValid && reqReady && overlayEnable && reqData.addr < 32'h0040_0000
    && reqData.kind == KIND_READ |=> respValid && respData.target == TGT_EXT && respData.addr[31:22] == 10'h180)
    else $error("overlay map wrong");
endmodule : mmd_decoder_monitor
bind mmd_decoder mmd_decoder_monitor #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) u_mon (.clk_sys(clk_sys),
  .nrst(nrst), .reqValid(reqValid), .reqData(reqData), .reqReady(reqReady), .respValid(respValid),
  .respData(respData), .eccEnable(eccEnable), .overlayEnable(overlayEnable), .flashReadControl(flashReadControl),
  .extWidth(extWidth), .flashBusy(flashBusy), .extPinGpioMode(extPinGpioMode));
`default_nettype wire

//--- bench/mmd_bus_master.sv
// Purpose: Bus master model issuing one request at a time.
// Assumes: Requests change at the falling edge.
// Notes:   A request is held until the edge that takes it.
`timescale 1ns/10ps
`default_nettype none
module mmd_bus_master
  import mmd_pkg::*;
(
  // Bus side
  input  wire logic               clk_sys,
  input  wire logic               reqReady,
  input  wire logic               respValid,
  input  wire mmd_pkg::mmd_resp_t respData,
  output var  logic               reqValid,
  output var  mmd_pkg::mmd_req_t  reqData
);
  initial
  begin
    reqValid = 1'b0;
    reqData  = '0;
  end
  task automatic access(input logic [31:0] a, input mmd_kind_t k, input mmd_size_t s,
                        output mmd_resp_t r, output bit ok);
    int n;
    n = 0;
    @(negedge clk_sys);
    reqValid = 1'b1;
    reqData  = '{a, k, s};
    while (reqReady !== 1'b1 && n < 40)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    reqValid = 1'b0;
    // Released lines show a changed pattern so a stale address cannot look valid.
    reqData  = ~reqData;
    while (respValid !== 1'b1 && n < 80)
    begin
      @(negedge clk_sys);
      n++;
    end
    r  = respData;
    ok = (respValid === 1'b1);
  endtask : access
endmodule : mmd_bus_master
`default_nettype wire

//--- bench/memory_map_decoder_bench.sv
// Purpose: Self-checking bench for the memory map decoder.
// Assumes: Short sequencer counts of two cycles each.
// Notes:   Random flash addresses come from a fixed-seed shift register.
`timescale 1ns/10ps
`default_nettype none
module memory_map_decoder_bench;
  import mmd_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, eccEnable = 1'b0, overlayEnable = 1'b0, frcWrite = 1'b0;
  logic extWidthWrite = 1'b0, extWidth8 = 1'b0, gpioRequest = 1'b1, reqValid, reqReady, respValid;
  logic flashBusy, clockLimitViolation, extPinGpioMode;
  logic [2:0] frcData = 3'h0, flashReadControl;
  logic [1:0] extWidth;
  logic [31:0] eraseFirst, eraseLast, seed = 32'h222D_964F, a;
  mmd_req_t reqData;
  mmd_resp_t respData, rsp;
  int n_mismatch = 0, n_checks = 0;
  logic [31:0] corner [8] = '{32'h0000_7FFF, 32'h0001_8000, 32'h0001_A000, 32'h0001_C000,
                              32'h0003_0000, 32'h0007_FFFF, 32'h0008_0000, 32'h001F_FFFF};
  logic [31:0] frAddr [6] = '{32'hFE00_0000, 32'hFEFF_FFFF, 32'hFFA0_4FFF, 32'hFFF8_7000, 32'hFFFF_E000, 32'hFFFF_FF00};
  logic [4:0] frIdx [6] = '{5'h0, 5'h0, 5'h5, 5'h9, 5'hA, 5'h19};
  logic [31:0] badAddr [4] = '{32'hFFF8_1000, 32'h0020_0000, 32'hFFA0_5000, 32'hFDFF_FFFF};
  always #50 clk_sys = ~clk_sys;
  mmd_decoder #(.PROG_CYC(2), .ERASE_CYC(2)) dut (.clk_sys(clk_sys), .nrst(nrst), .reqValid(reqValid),
    .reqData(reqData), .reqReady(reqReady), .respValid(respValid), .respData(respData), .eccEnable(eccEnable),
    .overlayEnable(overlayEnable), .frcWrite(frcWrite), .frcData(frcData), .extWidthWrite(extWidthWrite),
    .extWidth8(extWidth8), .gpioRequest(gpioRequest), .flashReadControl(flashReadControl), .extWidth(extWidth),
    .flashBusy(flashBusy), .clockLimitViolation(clockLimitViolation), .extPinGpioMode(extPinGpioMode),
    .eraseFirst(eraseFirst), .eraseLast(eraseLast));
  mmd_bus_master master (.clk_sys(clk_sys), .reqReady(reqReady), .respValid(respValid), .respData(respData),
    .reqValid(reqValid), .reqData(reqData));
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : lfsr
  function automatic logic [5:0] flashLoc(input logic [31:0] x);
    if (x[20:19] != 2'h0) return {x[20:19], 2'h0, x[18:17]};
    if (x[18:0] < 19'h1_8000) return {2'h0, 2'h0, x[16:15]};
    if (x[18:0] < 19'h1_C000) return {2'h0, 4'h3 + {3'h0, x[13]}};
    if (x[18:0] < 19'h2_0000) return 6'h05;
    if (x[18:0] < 19'h4_0000) return {2'h0, 4'h6 + {3'h0, x[16]}};
    return {2'h0, 4'h8 + {3'h0, x[17]}};
  endfunction : flashLoc
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic [31:0] x, input mmd_kind_t k, input mmd_size_t s);
    bit ok;
    master.access(x, k, s, rsp, ok);
    if (!ok) check(32'h0, 32'h1);
  endtask : acc
  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    #(3000 * 100);
    n_mismatch++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    check(32'(flashReadControl), 32'h0);
    check(32'(extWidth), 32'h2);
    check(32'({extPinGpioMode, clockLimitViolation}), 32'h0);
    for (int i = 0; i < 32; i++)
    begin
      a = (i < 8) ? corner[i] : (lfsr() & 32'h001F_FFFC);
      acc(a, KIND_READ, SIZE_WORD);
      check(32'({rsp.bank, rsp.sector}), 32'(flashLoc(a)));
    end
    foreach (frAddr[i])
    begin
      acc(frAddr[i], KIND_READ, SIZE_WORD);
      check(32'({rsp.target, rsp.frame}), 32'({TGT_FRAME, frIdx[i]}));
    end
    foreach (badAddr[i])
    begin
      acc(badAddr[i], KIND_READ, SIZE_WORD);
      check(32'(rsp.busError), 32'h1);
    end
    acc(32'h0000_0100, KIND_RSVD, SIZE_WORD);
    check(32'(rsp.busError), 32'h1);
    acc(32'h0001_A010, KIND_ERASE, SIZE_WORD);
    check(eraseFirst, 32'h0001_A000);
    check(eraseLast, 32'h0001_BFFF);
    acc(32'h0008_0001, KIND_PROG, SIZE_BYTE);
    check(32'(rsp.busError), 32'h1);
    acc(32'h0008_0002, KIND_PROG, SIZE_HALF);
    check(32'({rsp.busError, rsp.target}), 32'(TGT_FLASH));
    acc(32'h6200_0000, KIND_READ, SIZE_WORD);
    check(32'(rsp.busError), 32'h1);
    acc(32'h79FF_FFF0, KIND_READ, SIZE_WORD);
    check(32'({rsp.busError, rsp.extSelect}), 32'h3);
    extWidth8 = 1'b1;
    extWidthWrite = 1'b1;
    @(negedge clk_sys);
    extWidthWrite = 1'b0;
    check(32'(extWidth), 32'h1);
    acc(32'h7900_0000, KIND_READ, SIZE_WORD);
    check(32'(rsp.busError), 32'h1);
    acc(32'h78FF_FFF0, KIND_READ, SIZE_WORD);
    check(32'(rsp.busError), 32'h0);
    overlayEnable = 1'b1;
    eccEnable = 1'b1;
    acc(32'h0000_0100, KIND_READ, SIZE_WORD);
    check(32'({rsp.target, rsp.eccError}), 32'({TGT_EXT, 1'b1}));
    eccEnable = 1'b0;
    acc(32'h003F_FF00, KIND_READ, SIZE_WORD);
    check(32'({rsp.target, rsp.extSelect, rsp.eccError}), 32'({TGT_EXT, 3'h0}));
    overlayEnable = 1'b0;
    frcData = 3'h1;
    frcWrite = 1'b1;
    @(negedge clk_sys);
    frcWrite = 1'b0;
    acc(32'h0000_1234, KIND_READ, SIZE_WORD);
    check({rsp.addr[30:0], rsp.beat}, 32'h0000_2460);
    @(negedge clk_sys);
    check({respData.addr[30:0], respData.beat & respValid}, 32'h0000_2471);
    print_verdict();
  end
endmodule : memory_map_decoder_bench
`default_nettype wire
